// *** shared/ulfc_pkg.sv ***
// Purpose: Constants for the UART loopback and FIFO control block
// Assumes: Classic Wishbone slave, 32-bit data, word-aligned registers
// Notes: Twelve-bit registers; offsets and config word are local choices
// Function
// - Data echo bit 0 loops transmitted serial bits into receiver.
// - During data echo, transmit pin idles and receive pin ignored.
// - Handshake echo bit 1 feeds own RTS back as CTS.
// - Ready echo bit 2 feeds own DTR back as DSR.
// - Writing one to transmit flush bit 0 empties FIFO, self-clears.
// - Transmit FIFO count readable as eight bits in 7:0.
// - Writing one to receive flush bit 0 empties FIFO, self-clears.
// - Receive FIFO count readable as nine bits in 8:0.
// - Low latency forced on when baud rate below 40961.
// - Without low latency, forward at full packet or three idle chars.
// - Standard serial-class driver lowers packet threshold to 63 bytes.
// - With low latency, forward each received byte immediately.
// - Extended format bit zero normal mode, one selects wide mode.
package ulfc_pkg;
  localparam logic [7:0] ULFC_ECHO_OFS = 8'h00;
  localparam logic [7:0] ULFC_TXFL_OFS = 8'h04;
  localparam logic [7:0] ULFC_TXLV_OFS = 8'h08;
  localparam logic [7:0] ULFC_RXFL_OFS = 8'h0c;
  localparam logic [7:0] ULFC_RXLV_OFS = 8'h10;
  localparam logic [7:0] ULFC_LAT_OFS = 8'h14;
  localparam logic [7:0] ULFC_WIDE_OFS = 8'h18;
  localparam logic [7:0] ULFC_CFG_OFS = 8'h1c;
  localparam int ULFC_ECHO_DATA_BIT = 0;
  localparam int ULFC_ECHO_HS_BIT = 1;
  localparam int ULFC_ECHO_RDY_BIT = 2;
  localparam int ULFC_FLUSH_BIT = 0;
  localparam int ULFC_EN_BIT = 0;
  localparam int ULFC_CFG_CDC_BIT = 0;
  localparam int ULFC_REG_W = 12;
  localparam logic [11:0] ULFC_ECHO_RST = 12'h000;
  localparam logic [11:0] ULFC_LAT_RST = 12'h000;
  localparam logic [11:0] ULFC_WIDE_RST = 12'h000;
  localparam logic [11:0] ULFC_CFG_RST = 12'h000;
  localparam logic [23:0] ULFC_LOWLAT_BAUD = 24'd40961;
  localparam logic [9:0] ULFC_PKT_FULL = 10'd64;
  localparam logic [9:0] ULFC_PKT_CDC = 10'd63;
  localparam int ULFC_TIMEOUT_CHARS = 3;
endpackage

// *** hdl/ulfc_fifo.sv ***
// Purpose: Synchronous FIFO with flush and fill count
// Assumes: Single clock; read data registered
// Notes: Flush wins over push and pop in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ulfc_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 128,
  parameter int CW = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_flush,
  input wire logic i_push_valid,
  output logic o_push_ready,
  input wire logic [W-1:0] i_push_data,
  output logic o_pop_valid,
  input wire logic i_pop_ready,
  output logic [W-1:0] o_pop_data,
  output logic [CW-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_push;
  logic do_pop;
  logic [AW-1:0] rd_inc;
  logic [AW-1:0] head_ptr;
  logic [W-1:0] data_reg;

  assign o_push_ready = (count_reg != CW'(DEPTH)) && !i_flush;
  assign o_pop_valid = (count_reg != '0) && !i_flush;
  assign do_push = i_push_valid && o_push_ready;
  assign do_pop = o_pop_valid && i_pop_ready;
  assign o_count = count_reg;
  assign rd_inc = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
  assign head_ptr = i_flush ? '0 : (do_pop ? rd_inc : rd_ptr_reg);
  assign o_pop_data = data_reg;

  // Head word kept in a register; a push into the new head bypasses memory
  always_ff @(posedge i_mclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= i_push_data;
    end
    if (do_push && wr_ptr_reg == head_ptr) begin
      data_reg <= i_push_data;
    end else begin
      data_reg <= mem[head_ptr];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/ulfc_top.sv ***
// Purpose: Loopback, FIFO flush, fill counts and receive forwarding control
// Assumes: Serial bit engines and USB packet engine sit outside this block
// Notes: Registers on classic Wishbone; unmapped reads return zero
`timescale 1ns/1ps
`default_nettype none
module ulfc_top #(
  parameter int TX_DEPTH = 128,
  parameter int RX_DEPTH = 384,
  parameter int CHAR_W = 9
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Host side transmit characters into TX FIFO
  input wire logic i_tx_in_valid,
  output logic o_tx_in_ready,
  input wire logic [CHAR_W-1:0] i_tx_in_data,
  // TX FIFO toward serialiser
  output logic o_tx_char_valid,
  input wire logic i_tx_char_ready,
  output logic [CHAR_W-1:0] o_tx_char_data,
  // Serialiser bit and receiver bit
  input wire logic i_ser_tx_bit,
  output logic o_deser_rx_bit,
  // Serial pins
  output logic o_pin_tx,
  output logic o_pin_tx_oe,
  input wire logic i_pin_rx,
  // Modem handshakes
  input wire logic i_core_rts,
  input wire logic i_core_dtr,
  output logic o_core_cts,
  output logic o_core_dsr,
  output logic o_pin_rts,
  output logic o_pin_dtr,
  input wire logic i_pin_cts,
  input wire logic i_pin_dsr,
  // Deserialiser characters into RX FIFO
  input wire logic i_rx_char_valid,
  output logic o_rx_char_ready,
  input wire logic [CHAR_W-1:0] i_rx_char_data,
  input wire logic i_char_tick,
  // RX FIFO toward USB packet engine
  output logic o_rx_out_valid,
  input wire logic i_rx_out_ready,
  output logic [CHAR_W-1:0] o_rx_out_data,
  output logic o_rx_out_last,
  // Baud and mode
  input wire logic [23:0] i_baud_rate,
  output logic o_wide_mode
);
  //----------------------------------------------------------------
  // Register state
  //----------------------------------------------------------------
  logic [11:0] echo_reg;
  logic [11:0] lat_reg;
  logic [11:0] wide_reg;
  logic [11:0] cfg_reg;
  logic tx_flush_reg;
  logic rx_flush_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [7:0] tx_count;
  logic [8:0] rx_count;
  logic wb_req;
  logic wb_wr;
  logic lowlat_eff;

  assign wb_req = i_wb_cyc && i_wb_stb && !ack_reg;
  assign wb_wr = wb_req && i_wb_we && i_wb_sel[0] && i_wb_sel[1];
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  //----------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------
  logic [1:0] rx_sync_reg;
  logic [1:0] cts_sync_reg;
  logic [1:0] dsr_sync_reg;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_sync_reg <= 2'h3;
      cts_sync_reg <= 2'h0;
      dsr_sync_reg <= 2'h0;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], i_pin_rx};
      cts_sync_reg <= {cts_sync_reg[0], i_pin_cts};
      dsr_sync_reg <= {dsr_sync_reg[0], i_pin_dsr};
    end
  end

  //----------------------------------------------------------------
  // Echo paths
  //----------------------------------------------------------------
  logic echo_data;
  logic echo_hs;
  logic echo_rdy;
  assign echo_data = echo_reg[ulfc_pkg::ULFC_ECHO_DATA_BIT];
  assign echo_hs = echo_reg[ulfc_pkg::ULFC_ECHO_HS_BIT];
  assign echo_rdy = echo_reg[ulfc_pkg::ULFC_ECHO_RDY_BIT];

  // Registered so pins and receiver switch on the next sample
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin_tx <= 1'b1;
      o_pin_tx_oe <= 1'b1;
      o_deser_rx_bit <= 1'b1;
    end else begin
      o_deser_rx_bit <= echo_data ? i_ser_tx_bit : rx_sync_reg[1];
      o_pin_tx <= echo_data ? 1'b1 : i_ser_tx_bit;
      o_pin_tx_oe <= !echo_data;
    end
  end

  // Pins keep the core levels so the far end sees no glitch when looping
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_core_cts <= 1'b0;
      o_core_dsr <= 1'b0;
      o_pin_rts <= 1'b0;
      o_pin_dtr <= 1'b0;
    end else begin
      o_core_cts <= echo_hs ? i_core_rts : cts_sync_reg[1];
      o_core_dsr <= echo_rdy ? i_core_dtr : dsr_sync_reg[1];
      o_pin_rts <= i_core_rts;
      o_pin_dtr <= i_core_dtr;
    end
  end

  //----------------------------------------------------------------
  // FIFOs
  //----------------------------------------------------------------
  logic rx_pop;
  logic rx_avail;

  ulfc_fifo #(
    .W(CHAR_W),
    .DEPTH(TX_DEPTH),
    .CW(8)
  ) u_tx_fifo (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_flush(tx_flush_reg),
    .i_push_valid(i_tx_in_valid),
    .o_push_ready(o_tx_in_ready),
    .i_push_data(i_tx_in_data),
    .o_pop_valid(o_tx_char_valid),
    .i_pop_ready(i_tx_char_ready),
    .o_pop_data(o_tx_char_data),
    .o_count(tx_count)
  );

  ulfc_fifo #(
    .W(CHAR_W),
    .DEPTH(RX_DEPTH),
    .CW(9)
  ) u_rx_fifo (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_flush(rx_flush_reg),
    .i_push_valid(i_rx_char_valid),
    .o_push_ready(o_rx_char_ready),
    .i_push_data(i_rx_char_data),
    .o_pop_valid(rx_avail),
    .i_pop_ready(rx_pop),
    .o_pop_data(o_rx_out_data),
    .o_count(rx_count)
  );

  //----------------------------------------------------------------
  // Receive forwarding
  //----------------------------------------------------------------
  typedef enum logic [1:0] {
    ULFC_GATHER,
    ULFC_DRAIN
  } ulfc_fwd_type;

  ulfc_fwd_type fwd_reg;
  logic [9:0] left_reg;
  logic [1:0] idle_reg;
  logic [9:0] pkt_size;
  logic [9:0] rx_count_w;
  logic burst_ok;

  assign pkt_size = cfg_reg[ulfc_pkg::ULFC_CFG_CDC_BIT] ?
    ulfc_pkg::ULFC_PKT_CDC : ulfc_pkg::ULFC_PKT_FULL;
  assign rx_count_w = {1'b0, rx_count};
  assign lowlat_eff = lat_reg[ulfc_pkg::ULFC_EN_BIT] ||
    (i_baud_rate < ulfc_pkg::ULFC_LOWLAT_BAUD);
  // Packet full or three quiet character times
  assign burst_ok = (rx_count_w >= pkt_size) ||
    (idle_reg == 2'(ulfc_pkg::ULFC_TIMEOUT_CHARS) && rx_count != '0);
  assign o_rx_out_valid = rx_avail &&
    (lowlat_eff || fwd_reg == ULFC_DRAIN);
  assign rx_pop = o_rx_out_valid && i_rx_out_ready;
  assign o_rx_out_last = lowlat_eff || left_reg == 10'd1;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idle_reg <= 2'h0;
    end else if (i_rx_char_valid || rx_flush_reg || rx_count == '0) begin
      idle_reg <= 2'h0;
    end else if (i_char_tick && idle_reg != 2'(ulfc_pkg::ULFC_TIMEOUT_CHARS)) begin
      idle_reg <= idle_reg + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fwd_reg <= ULFC_GATHER;
      left_reg <= 10'h000;
    end else if (rx_flush_reg || lowlat_eff) begin
      fwd_reg <= ULFC_GATHER;
      left_reg <= 10'h000;
    end else begin
      unique case (fwd_reg)
        ULFC_GATHER: begin
          if (burst_ok) begin
            fwd_reg <= ULFC_DRAIN;
            left_reg <= (rx_count_w < pkt_size) ? rx_count_w : pkt_size;
          end
        end
        ULFC_DRAIN: begin
          if (rx_pop) begin
            left_reg <= left_reg - 10'h001;
            if (left_reg == 10'd1) begin
              fwd_reg <= ULFC_GATHER;
            end
          end
        end
      endcase
    end
  end

  assign o_wide_mode = wide_reg[ulfc_pkg::ULFC_EN_BIT];

  //----------------------------------------------------------------
  // Wishbone register access
  //----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // Full 12 bits kept as written; upper bits are software's to keep zero
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      echo_reg <= ulfc_pkg::ULFC_ECHO_RST;
      lat_reg <= ulfc_pkg::ULFC_LAT_RST;
      wide_reg <= ulfc_pkg::ULFC_WIDE_RST;
      cfg_reg <= ulfc_pkg::ULFC_CFG_RST;
    end else if (wb_wr) begin
      unique case (i_wb_adr)
        ulfc_pkg::ULFC_ECHO_OFS: echo_reg <= i_wb_dat[11:0];
        ulfc_pkg::ULFC_LAT_OFS: lat_reg <= i_wb_dat[11:0];
        ulfc_pkg::ULFC_WIDE_OFS: wide_reg <= i_wb_dat[11:0];
        ulfc_pkg::ULFC_CFG_OFS: cfg_reg <= i_wb_dat[11:0];
        default: begin
        end
      endcase
    end
  end

  // Flush strobes last one cycle and clear themselves
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_flush_reg <= 1'b0;
      rx_flush_reg <= 1'b0;
    end else begin
      tx_flush_reg <= wb_wr && i_wb_adr == ulfc_pkg::ULFC_TXFL_OFS &&
        i_wb_dat[ulfc_pkg::ULFC_FLUSH_BIT];
      rx_flush_reg <= wb_wr && i_wb_adr == ulfc_pkg::ULFC_RXFL_OFS &&
        i_wb_dat[ulfc_pkg::ULFC_FLUSH_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wb_req && !i_wb_we) begin
      unique case (i_wb_adr)
        ulfc_pkg::ULFC_ECHO_OFS: rdat_reg <= {20'h00000, echo_reg};
        ulfc_pkg::ULFC_TXLV_OFS: rdat_reg <= {24'h000000, tx_count};
        ulfc_pkg::ULFC_RXLV_OFS: rdat_reg <= {23'h0, rx_count};
        ulfc_pkg::ULFC_LAT_OFS:
          rdat_reg <= {20'h00000, lat_reg[11:1], lowlat_eff};
        ulfc_pkg::ULFC_WIDE_OFS: rdat_reg <= {20'h00000, wide_reg};
        ulfc_pkg::ULFC_CFG_OFS: rdat_reg <= {20'h00000, cfg_reg};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sim/ulfc_assertions.sv ***
// Purpose: Port checks for ulfc_top
// Assumes: Bound from the bench top, one clock domain
// Notes: Echo state is tracked from acked register writes
`timescale 1ns/1ps
`default_nettype none
module ulfc_assertions (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_ser_tx_bit,
  input wire logic o_deser_rx_bit,
  input wire logic o_pin_tx,
  input wire logic o_pin_tx_oe,
  input wire logic i_core_rts,
  input wire logic i_core_dtr,
  input wire logic o_core_cts,
  input wire logic o_core_dsr,
  input wire logic o_pin_rts,
  input wire logic o_pin_dtr,
  input wire logic i_pin_cts,
  input wire logic i_pin_dsr,
  input wire logic o_rx_out_valid,
  input wire logic o_rx_out_last,
  input wire logic [23:0] i_baud_rate,
  input wire logic o_wide_mode
);
  logic [2:0] echo_reg;
  logic wr_ok;
  assign wr_ok = o_wb_ack && i_wb_we && i_wb_sel[1:0] == 2'h3;
  // Lags the design by one edge, which its output flop matches
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      echo_reg <= 3'h0;
    end else if (wr_ok && i_wb_adr == ulfc_pkg::ULFC_ECHO_OFS) begin
      echo_reg <= i_wb_dat[2:0];
    end
  end
  // Pin paths need three edges after reset before history is valid
  logic [1:0] up_reg;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  chk_ack_next_cycle: assert property
    (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  chk_tx_pin_off: assert property
    (echo_reg[0] |-> !o_pin_tx_oe && o_pin_tx)
    else $error("tx pin driven in echo");
  chk_rx_from_tx: assert property
    (!o_pin_tx_oe && !$past(o_pin_tx_oe)
     |-> o_deser_rx_bit == $past(i_ser_tx_bit))
    else $error("receiver not fed from transmitter");
  chk_cts_echo: assert property
    (echo_reg[1] |-> o_core_cts == $past(i_core_rts))
    else $error("cts not fed from rts");
  chk_dsr_echo: assert property
    (echo_reg[2] |-> o_core_dsr == $past(i_core_dtr))
    else $error("dsr not fed from dtr");
  chk_pins_follow_core: assert property
    (up_reg != 2'h0 |-> o_pin_rts == $past(i_core_rts) &&
     o_pin_dtr == $past(i_core_dtr))
    else $error("modem pins not following core");
  chk_cts_from_pin: assert property
    (up_reg == 2'h3 && !echo_reg[1] |-> o_core_cts == $past(i_pin_cts, 3))
    else $error("cts not taken from pin");
  chk_dsr_from_pin: assert property
    (up_reg == 2'h3 && !echo_reg[2] |-> o_core_dsr == $past(i_pin_dsr, 3))
    else $error("dsr not taken from pin");
  chk_wide_by_write: assert property
    ($changed(o_wide_mode)
     |-> wr_ok && i_wb_adr == ulfc_pkg::ULFC_WIDE_OFS)
    else $error("wide mode moved without write");
  chk_rx_flush_empty: assert property
    (wr_ok && i_wb_adr == ulfc_pkg::ULFC_RXFL_OFS && i_wb_dat[0]
     |-> ##2 !o_rx_out_valid)
    else $error("receive data after flush");
  chk_slow_each_last: assert property
    (o_rx_out_valid && i_baud_rate < ulfc_pkg::ULFC_LOWLAT_BAUD
     |-> o_rx_out_last)
    else $error("slow baud not forwarding per byte");
  cov_echo_on: cover property
    (wr_ok && i_wb_adr == ulfc_pkg::ULFC_ECHO_OFS && i_wb_dat[0]);
  cov_gathered: cover property (o_rx_out_valid && !o_rx_out_last);
  cov_tx_flush: cover property
    (wr_ok && i_wb_adr == ulfc_pkg::ULFC_TXFL_OFS);
endmodule
`default_nettype wire

// *** sim/ulfc_peer.sv ***
// Purpose: Serial line peer driving the receive and handshake pins
// Assumes: Pins never idle, so ignored RX and CTS inputs differ from loops
// Notes: RX and CTS patterns differ from the bench core levels; DSR matches DTR
`timescale 1ns/1ps
`default_nettype none
module ulfc_peer (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  output logic o_pin_rx,
  output logic o_pin_cts,
  output logic o_pin_dsr
);
  logic [3:0] cnt_reg;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  assign o_pin_rx = cnt_reg[1];
  assign o_pin_cts = cnt_reg[2];
  assign o_pin_dsr = ~cnt_reg[0];
endmodule
`default_nettype wire

// *** sim/ulfc_top_test.sv ***
// Purpose: Register level tests of ulfc_top
// Assumes: Wishbone answer within a few cycles
// Notes: Forwarding is stalled except in the latency step
`timescale 1ns/1ps
`default_nettype none
module ulfc_top_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, tir, tcv, dbit, ptx, poe, prx, cts, dsr, prts, pdtr;
  logic pcts, pdsr, rcr, ov, olast, wide;
  logic [8:0] tcd, od;
  logic txv = 1'b0, tcr = 1'b0, ser = 1'b0, rts = 1'b0, dtr = 1'b0;
  logic rxv = 1'b0, tick = 1'b0, ordy = 1'b0;
  logic [8:0] txd = 9'h000, rxd = 9'h000;
  logic [23:0] baud = 24'h01c200;
  int n_mismatch = 0, check_count = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    ser <= ~ser;
    rts <= ser;
    dtr <= ~rts;
  end
  ulfc_top DUT (.i_mclk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_tx_in_valid(txv), .o_tx_in_ready(tir), .i_tx_in_data(txd),
    .o_tx_char_valid(tcv), .i_tx_char_ready(tcr),
    .o_tx_char_data(tcd), .i_ser_tx_bit(ser), .o_deser_rx_bit(dbit),
    .o_pin_tx(ptx), .o_pin_tx_oe(poe), .i_pin_rx(prx),
    .i_core_rts(rts), .i_core_dtr(dtr), .o_core_cts(cts),
    .o_core_dsr(dsr), .o_pin_rts(prts), .o_pin_dtr(pdtr),
    .i_pin_cts(pcts), .i_pin_dsr(pdsr), .i_rx_char_valid(rxv),
    .o_rx_char_ready(rcr), .i_rx_char_data(rxd), .i_char_tick(tick),
    .o_rx_out_valid(ov), .i_rx_out_ready(ordy), .o_rx_out_data(od),
    .o_rx_out_last(olast), .i_baud_rate(baud), .o_wide_mode(wide));
  ulfc_peer u_peer (.i_mclk(clk), .i_rst_b(rst_b), .o_pin_rx(prx),
    .o_pin_cts(pcts), .o_pin_dsr(pdsr));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      results();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Pushes n characters, then one settling edge
  task automatic push(input bit r, input int n);
    for (int i = 0; i < n; i++) begin
      rxv <= r;
      txv <= !r;
      rxd <= 9'(i);
      txd <= 9'(i);
      @(posedge clk);
    end
    rxv <= 1'b0;
    txv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
    done("reset");
    wr(ulfc_pkg::ULFC_ECHO_OFS, 32'h7);
    rd(ulfc_pkg::ULFC_ECHO_OFS, 32'h7);
    chk(32'(poe), 32'h0);
    wr(ulfc_pkg::ULFC_WIDE_OFS, 32'h1);
    chk(32'(wide), 32'h1);
    done("echo");
    push(1'b0, 5);
    rd(ulfc_pkg::ULFC_TXLV_OFS, 32'h5);
    wr(ulfc_pkg::ULFC_ECHO_OFS, 32'h0);
    rd(ulfc_pkg::ULFC_TXLV_OFS, 32'h5);
    chk(32'(tcd), 32'h0);
    wr(ulfc_pkg::ULFC_TXFL_OFS, 32'h1);
    rd(ulfc_pkg::ULFC_TXFL_OFS, 32'h0);
    rd(ulfc_pkg::ULFC_TXLV_OFS, 32'h0);
    chk({30'h0, tir, tcv}, 32'h2);
    done("tx flush");
    push(1'b1, 2);
    rd(ulfc_pkg::ULFC_RXLV_OFS, 32'h2);
    chk(32'(ov), 32'h0);
    repeat (3) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
    chk(32'(ov), 32'h1);
    wr(ulfc_pkg::ULFC_RXFL_OFS, 32'h1);
    rd(ulfc_pkg::ULFC_RXLV_OFS, 32'h0);
    chk({30'h0, rcr, ov}, 32'h2);
    push(1'b1, 63);
    chk(32'(ov), 32'h0);
    push(1'b1, 1);
    @(posedge clk);
    chk(32'(ov), 32'h1);
    rd(ulfc_pkg::ULFC_RXLV_OFS, 32'h40);
    wr(ulfc_pkg::ULFC_RXFL_OFS, 32'h1);
    wr(ulfc_pkg::ULFC_CFG_OFS, 32'h1);
    push(1'b1, 63);
    @(posedge clk);
    chk(32'(ov), 32'h1);
    wr(ulfc_pkg::ULFC_RXFL_OFS, 32'h1);
    done("packet");
    wr(ulfc_pkg::ULFC_LAT_OFS, 32'h1);
    push(1'b1, 2);
    chk({30'h0, ov, olast}, 32'h3);
    ordy <= 1'b1;
    // Data taken at the edge that pops it
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      chk(32'(od), 32'(i));
    end
    ordy <= 1'b0;
    rd(ulfc_pkg::ULFC_RXLV_OFS, 32'h0);
    wr(ulfc_pkg::ULFC_LAT_OFS, 32'h0);
    baud <= 24'h002580;
    rd(ulfc_pkg::ULFC_LAT_OFS, 32'h1);
    push(1'b1, 1);
    chk({30'h0, ov, olast}, 32'h3);
    wr(ulfc_pkg::ULFC_RXFL_OFS, 32'h1);
    baud <= 24'h01c200;
    rd(ulfc_pkg::ULFC_LAT_OFS, 32'h0);
    done("latency");
    results();
  end
endmodule
bind ulfc_top ulfc_assertions u_chk (.i_mclk, .i_rst_b, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack,
  .i_ser_tx_bit, .o_deser_rx_bit, .o_pin_tx, .o_pin_tx_oe, .i_core_rts,
  .i_core_dtr, .o_core_cts, .o_core_dsr, .o_pin_rts, .o_pin_dtr,
  .i_pin_cts, .i_pin_dsr, .o_rx_out_valid,
  .o_rx_out_last, .i_baud_rate, .o_wide_mode);
`default_nettype wire
